// >>> pkg/rx_alarm_regs.svh
// Offsets, field positions, reset values and counts of the receive alarm monitor.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef RX_ALARM_REGS_SVH
`define RX_ALARM_REGS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define ALARM_STATE_OFS      8'h03
`define INT_STATUS_OFS       8'h04
`define INT_MASK_OFS         8'h05
`define CHAN_CTRL_OFS        8'h06

// -----------------------------------------------------------------
// Alarm state bit positions
// -----------------------------------------------------------------
`define BIT_OVERALL_ABSENT   1
`define BIT_LOCK_LOST        2
`define BIT_FIFO_LIMIT       3
`define BIT_ANALOG_ABSENT    4
`define BIT_DIGITAL_ABSENT   5

// -----------------------------------------------------------------
// Control fields and reset values
// -----------------------------------------------------------------
`define CTRL_RATE_LSB        0
`define CTRL_SYNTH_BIT       2
`define CTRL_JA_EN_BIT       3
`define CTRL_JA_DEPTH_BIT    4
`define CTRL_RESET           8'h00
`define MASK_RESET           8'h00
`define STATUS_RESET         8'h00
`define EVENT_BITS           8'h3E

// -----------------------------------------------------------------
// Detector counts
// -----------------------------------------------------------------
`define ZERO_RUN_DECLARE     160
`define DENSITY_PCT          33
`define DENSITY_WINDOW       32
`define E3_ZERO_DECLARE      32
`define E3_CLEAR_RUN         4
`define FIFO_MARGIN          2
`define FIFO_DEPTH_SMALL     16
`define FIFO_DEPTH_LARGE     32
`define LOCK_TOL_PPM         5000
`define PPM_SCALE            1000000
`define LOCK_WINDOW          2048

`endif

// >>> pkg/rx_alarm_pkg.sv
// Types shared by the receive alarm monitor.
// Assumes nothing of its surroundings.
package rx_alarm_pkg;

	// -----------------------------------------------------------------
	// Line rate selection
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_DS3  = 2'b00,
		RATE_E3   = 2'b01,
		RATE_STS1 = 2'b10,
		RATE_RSVD = 2'b11
	} line_rate_e;

	typedef logic [7:0] reg_byte_t;

endpackage : rx_alarm_pkg

// >>> hw/rx_channel_alarm_monitor.sv
// Receive alarm monitor for one line channel: signal loss, FIFO limit, clock lock.
// Assumes recovered clock, pulse, reference clocks and analogue flag arrive as
// asynchronous pins; the FIFO fill level comes from logic on mclk_i.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "rx_alarm_regs.svh"

module rx_channel_alarm_monitor #(
	parameter int LOCK_WINDOW = `LOCK_WINDOW,
	parameter int DENS_WIN    = `DENSITY_WINDOW,
	parameter int FILL_W      = 6
) (
	input  wire logic              mclk_i,
	input  wire logic              srst_i,
	input  wire logic [7:0]        addr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [7:0]        rdata_o,
	output logic                   irq_o,
	input  wire logic              rclk_i,
	input  wire logic              rpulse_i,
	input  wire logic              ref_osc_clk_i,
	input  wire logic              synth_clk_i,
	input  wire logic              analog_absent_i,
	input  wire logic [FILL_W-1:0] ja_fill_i
);

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [4:0] meta_reg;
	logic [4:0] sync_reg;
	logic       rclk_d_reg;
	logic       ref_d_reg;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			meta_reg <= 5'h00;
			sync_reg <= 5'h00;
		end else begin
			meta_reg <= {analog_absent_i, synth_clk_i, ref_osc_clk_i, rpulse_i, rclk_i};
			sync_reg <= meta_reg;
		end
	end

	logic [7:0] ctrl_reg;
	rx_alarm_pkg::line_rate_e rate;
	logic       synth_mode;
	logic       ja_enable;
	logic       ja_large;
	logic       ref_level;

	assign rate       = rx_alarm_pkg::line_rate_e'(ctrl_reg[`CTRL_RATE_LSB +: 2]);
	assign synth_mode = ctrl_reg[`CTRL_SYNTH_BIT];
	assign ja_enable  = ctrl_reg[`CTRL_JA_EN_BIT];
	assign ja_large   = ctrl_reg[`CTRL_JA_DEPTH_BIT];
	assign ref_level  = synth_mode ? sync_reg[3] : sync_reg[2];

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rclk_d_reg <= 1'b0;
			ref_d_reg  <= 1'b0;
		end else begin
			rclk_d_reg <= sync_reg[0];
			ref_d_reg  <= ref_level;
		end
	end

	logic bit_tick;
	logic ref_tick;
	logic bit_val;
	assign bit_tick = sync_reg[0] & ~rclk_d_reg;
	assign ref_tick = ref_level & ~ref_d_reg;
	assign bit_val  = sync_reg[1];

	// -----------------------------------------------------------------
	// Digital absence detector
	// -----------------------------------------------------------------
	logic [7:0]          zero_run_reg;
	logic [DENS_WIN-1:0] hist_reg;
	logic [5:0]          win_fill_reg;
	logic                digital_reg;
	logic [7:0]          ones;
	logic                dens_ok;

	function automatic logic [7:0] popcount(input logic [DENS_WIN-1:0] v);
		logic [7:0] n;
		n = 8'h00;
		for (int i = 0; i < DENS_WIN; i++) begin
			n = n + {7'h00, v[i]};
		end
		return n;
	endfunction : popcount

	assign ones = popcount(hist_reg);
	// Window must hold real bits, else an empty history could clear early
	assign dens_ok = (win_fill_reg >= 6'(DENS_WIN)) &&
		(32'(ones) * 100 >= `DENSITY_PCT * DENS_WIN);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			zero_run_reg <= 8'h00;
			hist_reg     <= '0;
			win_fill_reg <= 6'h00;
		end else if (bit_tick) begin
			hist_reg <= {hist_reg[DENS_WIN-2:0], bit_val};
			if (win_fill_reg < 6'(DENS_WIN)) begin
				win_fill_reg <= win_fill_reg + 6'h01;
			end
			if (bit_val) begin
				zero_run_reg <= 8'h00;
			end else if (zero_run_reg < 8'(`ZERO_RUN_DECLARE)) begin
				zero_run_reg <= zero_run_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			digital_reg <= 1'b0;
		end else if (zero_run_reg == 8'(`ZERO_RUN_DECLARE)) begin
			digital_reg <= 1'b1;
		end else if (digital_reg && dens_ok) begin
			digital_reg <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// E3 zero-run detector
	// -----------------------------------------------------------------
	logic e3_reg;
	logic clear_run_seen;
	logic [`E3_CLEAR_RUN-1:0] run_mask;

	assign run_mask = '1;
	always_comb begin
		clear_run_seen = 1'b0;
		for (int i = 0; i <= DENS_WIN - `E3_CLEAR_RUN; i++) begin
			if ((hist_reg[i +: `E3_CLEAR_RUN] | ~run_mask) == ~run_mask) begin
				clear_run_seen = 1'b1;
			end
		end
	end

	// Clear when a full window shows no long zero run, as line coding guarantees
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			e3_reg <= 1'b0;
		end else if (zero_run_reg >= 8'(`E3_ZERO_DECLARE)) begin
			e3_reg <= 1'b1;
		end else if (e3_reg && !clear_run_seen && win_fill_reg >= 6'(DENS_WIN)) begin
			e3_reg <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// FIFO limit and clock lock
	// -----------------------------------------------------------------
	logic              fifo_near_limit;
	logic [FILL_W-1:0] depth;
	assign depth = ja_large ? FILL_W'(`FIFO_DEPTH_LARGE) : FILL_W'(`FIFO_DEPTH_SMALL);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fifo_near_limit <= 1'b0;
		end else begin
			fifo_near_limit <= ja_enable &&
				(ja_fill_i <= FILL_W'(`FIFO_MARGIN) ||
				ja_fill_i >= depth - FILL_W'(`FIFO_MARGIN));
		end
	end

	logic [15:0] ref_cnt_reg;
	logic [15:0] rec_cnt_reg;
	logic        clock_lock_lost;
	logic        win_end;
	logic [63:0] abs_diff;

	assign win_end  = ref_tick && (ref_cnt_reg == 16'(LOCK_WINDOW - 1));
	assign abs_diff = (rec_cnt_reg >= 16'(LOCK_WINDOW)) ?
		64'(rec_cnt_reg - 16'(LOCK_WINDOW)) : 64'(16'(LOCK_WINDOW) - rec_cnt_reg);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ref_cnt_reg <= 16'h0000;
			rec_cnt_reg <= 16'h0000;
		end else if (win_end) begin
			ref_cnt_reg <= 16'h0000;
			rec_cnt_reg <= {15'h0000, bit_tick};
		end else begin
			if (ref_tick) begin
				ref_cnt_reg <= ref_cnt_reg + 16'h0001;
			end
			if (bit_tick && rec_cnt_reg != 16'hFFFF) begin
				rec_cnt_reg <= rec_cnt_reg + 16'h0001;
			end
		end
	end

	// Verdict only per window; a dead recovered clock still shows after one window
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			clock_lock_lost <= 1'b0;
		end else if (win_end) begin
			clock_lock_lost <= abs_diff * 64'(`PPM_SCALE) >=
				64'(`LOCK_TOL_PPM) * 64'(LOCK_WINDOW);
		end
	end

	// -----------------------------------------------------------------
	// Alarm word
	// -----------------------------------------------------------------
	logic       analog_absent;
	logic       signal_absent;
	logic [7:0] alarm_word;

	assign analog_absent = sync_reg[4];
	assign signal_absent = (rate == rx_alarm_pkg::RATE_E3) ? e3_reg :
		(analog_absent | digital_reg);

	always_comb begin
		alarm_word = 8'h00;
		alarm_word[`BIT_OVERALL_ABSENT] = signal_absent;
		alarm_word[`BIT_LOCK_LOST]      = clock_lock_lost;
		alarm_word[`BIT_FIFO_LIMIT]     = fifo_near_limit;
		alarm_word[`BIT_ANALOG_ABSENT]  = analog_absent;
		alarm_word[`BIT_DIGITAL_ABSENT] = digital_reg;
	end

	// -----------------------------------------------------------------
	// Register port and interrupts
	// -----------------------------------------------------------------
	logic [7:0] mask_reg;
	logic [7:0] status_reg;
	logic [7:0] alarm_d_reg;
	logic [7:0] rise;
	logic [7:0] clr;

	assign rise = alarm_word & ~alarm_d_reg & 8'(`EVENT_BITS);
	assign clr  = (wr_i && addr_i == `INT_STATUS_OFS) ? wdata_i : 8'h00;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ctrl_reg <= `CTRL_RESET;
			mask_reg <= `MASK_RESET;
		end else if (wr_i) begin
			// Alarm offset is not decoded for writes
			if (addr_i == `CHAN_CTRL_OFS) begin
				ctrl_reg <= wdata_i;
			end
			if (addr_i == `INT_MASK_OFS) begin
				mask_reg <= wdata_i & 8'(`EVENT_BITS);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			alarm_d_reg <= 8'h00;
			status_reg  <= `STATUS_RESET;
		end else begin
			alarm_d_reg <= alarm_word;
			// Set wins over a clear in the same cycle
			status_reg  <= (status_reg & ~clr) | rise;
		end
	end

	assign irq_o = |(status_reg & mask_reg);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i)
				`ALARM_STATE_OFS: rdata_o <= alarm_word;
				`INT_STATUS_OFS:  rdata_o <= status_reg;
				`INT_MASK_OFS:    rdata_o <= mask_reg;
				`CHAN_CTRL_OFS:   rdata_o <= ctrl_reg;
				default:          rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	sequence s_absent_declared;
		digital_reg && !(zero_run_reg == 8'(`ZERO_RUN_DECLARE));
	endsequence
	sequence s_density_back;
		dens_ok;
	endsequence

	property p_declare;
		zero_run_reg == 8'(`ZERO_RUN_DECLARE) |=> digital_reg;
	endproperty
	a_declare: assert property (p_declare) else $error("absence not declared");

	property p_clear;
		s_absent_declared ##0 s_density_back |=> !digital_reg;
	endproperty
	a_clear: assert property (p_clear) else $error("absence not cleared");

	property p_bit5;
		rd_i && addr_i == `ALARM_STATE_OFS |=> rdata_o[5] == $past(digital_reg);
	endproperty
	a_bit5: assert property (p_bit5) else $error("bit 5 wrong");

	property p_bit4;
		rd_i && addr_i == `ALARM_STATE_OFS |=> rdata_o[4] == $past(sync_reg[4]);
	endproperty
	a_bit4: assert property (p_bit4) else $error("bit 4 wrong");

	property p_or;
		rate != rx_alarm_pkg::RATE_E3 |-> signal_absent == (analog_absent | digital_reg);
	endproperty
	a_or: assert property (p_or) else $error("overall absence not OR");

	property p_fifo;
		ja_enable && ja_fill_i <= FILL_W'(`FIFO_MARGIN) && !$past(srst_i)
			##1 !$changed(ctrl_reg) |-> fifo_near_limit;
	endproperty
	a_fifo: assert property (p_fifo) else $error("fifo limit missed");

	property p_fifo_off;
		!$past(ja_enable) |-> !fifo_near_limit;
	endproperty
	a_fifo_off: assert property (p_fifo_off) else $error("fifo limit while off");

	property p_lock;
		win_end && abs_diff > 64'(LOCK_WINDOW) / 64'd100 |=> clock_lock_lost;
	endproperty
	a_lock: assert property (p_lock) else $error("lock loss missed");

	property p_e3;
		rate == rx_alarm_pkg::RATE_E3 |-> signal_absent == e3_reg;
	endproperty
	a_e3: assert property (p_e3) else $error("E3 absence not followed");

	property p_ro;
		wr_i && addr_i == `ALARM_STATE_OFS ##1 rd_i && addr_i == `ALARM_STATE_OFS
			|=> rdata_o == $past(alarm_word);
	endproperty
	a_ro: assert property (p_ro) else $error("alarm word altered");

	property p_setwins;
		rise[1] && clr[1] |=> status_reg[1];
	endproperty
	a_setwins: assert property (p_setwins) else $error("event lost on clear");

endmodule : rx_channel_alarm_monitor

// >>> dv/line_signal_model.sv
// Behavioural far end: incoming line signal plus the two reference clocks.
// Assumes the bench picks the repeating 32-bit pulse pattern and the clock skew.
`timescale 1ns/1ps

module line_signal_model (
	input  wire logic [31:0] pattern_i,
	input  wire logic        skew_i,
	output logic             rclk_o,
	output logic             rpulse_o,
	output logic             ref_osc_clk_o,
	output logic             synth_clk_o
);
	logic [4:0] idx;

	// -----------------------------------------------------------------
	// Clocks
	// -----------------------------------------------------------------
	// Recovered clock runs free; skew stretches it by 5 percent
	initial begin
		rclk_o = 1'b0;
		forever begin
			// Unknown skew at time zero must not give a zero delay
			#((skew_i === 1'b1) ? 21 : 20);
			rclk_o = ~rclk_o;
		end
	end

	initial begin
		ref_osc_clk_o = 1'b0;
		forever #20 ref_osc_clk_o = ~ref_osc_clk_o;
	end

	// Synthesizer sits 5 percent slow so the reference choice shows
	initial begin
		synth_clk_o = 1'b0;
		forever #21 synth_clk_o = ~synth_clk_o;
	end

	// -----------------------------------------------------------------
	// Pulses
	// -----------------------------------------------------------------
	// Changed on the falling edge, half a bit away from sampling
	initial begin
		idx      = 5'h00;
		rpulse_o = 1'b0;
	end

	always @(negedge rclk_o) begin
		rpulse_o <= pattern_i[idx];
		idx      <= idx + 5'h01;
	end
endmodule : line_signal_model

// >>> dv/rx_channel_alarm_monitor_test.sv
// Self-checking bench of the receive alarm monitor, register sequences.
// Assumes line_signal_model as far end; lock window shortened to 256.
`timescale 1ns/1ps

module rx_channel_alarm_monitor_test;
	logic        mclk_i;
	logic        srst_i;
	logic [7:0]  addr_i;
	logic [7:0]  wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [7:0]  rdata_o;
	logic        irq_o;
	logic        rclk;
	logic        rpulse;
	logic        osc_clk;
	logic        syn_clk;
	logic        analog_absent;
	logic [5:0]  ja_fill;
	logic [31:0] pattern;
	logic        skew;
	int          error_cnt;
	int          tests_run;
	logic [7:0]  f_ctrl[12] = '{8'h00, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08,
		8'h08, 8'h18, 8'h18, 8'h18, 8'h18, 8'h00};
	logic [5:0]  f_fill[12] = '{6'h01, 6'h00, 6'h02, 6'h03, 6'h0D, 6'h0E,
		6'h10, 6'h0E, 6'h1D, 6'h1E, 6'h02, 6'h1E};
	logic [7:0]  f_exp[12]  = '{8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h08,
		8'h08, 8'h00, 8'h00, 8'h08, 8'h08, 8'h00};

	rx_channel_alarm_monitor #(.LOCK_WINDOW(256)) DUT (
		.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.rclk_i(rclk), .rpulse_i(rpulse), .ref_osc_clk_i(osc_clk),
		.synth_clk_i(syn_clk), .analog_absent_i(analog_absent), .ja_fill_i(ja_fill)
	);

	line_signal_model far_end (
		.pattern_i(pattern), .skew_i(skew), .rclk_o(rclk), .rpulse_o(rpulse),
		.ref_osc_clk_o(osc_clk), .synth_clk_o(syn_clk)
	);

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	// -----------------------------------------------------------------
	// Access tasks
	// -----------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge mclk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), exp, rdata_o & m);
	endtask : rchk

	task automatic bits(input int n);
		repeat (n) @(posedge rclk);
		@(posedge mclk_i);
	endtask : bits

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	// Whole run is near 20000 cycles
	initial begin
		repeat (80000) @(posedge mclk_i);
		error_cnt++;
		final_report();
	end

	// -----------------------------------------------------------------
	// Tests
	// -----------------------------------------------------------------
	initial begin
		error_cnt = 0;
		tests_run = 0;
		srst_i = 1'b1; addr_i = 8'h00; wdata_i = 8'h00; wr_i = 1'b0; rd_i = 1'b0;
		analog_absent = 1'b0; ja_fill = 6'h08; pattern = 32'hFFFFFFFF; skew = 1'b0;
		repeat (3) @(posedge mclk_i);
		srst_i <= 1'b0;
		rchk(8'h04, 8'h00, 8'hFF);
		rchk(8'h05, 8'h00, 8'hFF);
		rchk(8'h06, 8'h00, 8'hFF);
		rchk(8'h10, 8'h00, 8'hFF);
		bits(64);
		rchk(8'h03, 8'h00, 8'hFF);
		$display("test reset done");

		pattern <= 32'h00000000;
		bits(150);
		rchk(8'h03, 8'h00, 8'hFF);
		bits(20);
		rchk(8'h03, 8'h22, 8'hFF);
		pattern <= 32'h000003FF;
		bits(100);
		rchk(8'h03, 8'h22, 8'hFF);
		pattern <= 32'h000007FF;
		bits(40);
		rchk(8'h03, 8'h00, 8'hFF);
		pattern <= 32'hFFFFFFFF;
		$display("test digital absence done");

		wr(8'h04, 8'hFF);
		rchk(8'h04, 8'h00, 8'hFF);
		wr(8'h05, 8'hFF);
		rchk(8'h05, 8'h3E, 8'hFF);
		chk("irq idle", 8'h00, {7'h00, irq_o});
		analog_absent <= 1'b1;
		repeat (10) @(posedge mclk_i);
		rchk(8'h03, 8'h12, 8'hFF);
		wr(8'h03, 8'hFF);
		wr(8'h10, 8'hFF);
		rchk(8'h03, 8'h12, 8'hFF);
		rchk(8'h04, 8'h12, 8'hFF);
		chk("irq set", 8'h01, {7'h00, irq_o});
		wr(8'h05, 8'h00);
		chk("irq masked", 8'h00, {7'h00, irq_o});
		wr(8'h05, 8'h02);
		chk("irq unmasked", 8'h01, {7'h00, irq_o});
		wr(8'h04, 8'h12);
		chk("irq cleared", 8'h00, {7'h00, irq_o});
		rchk(8'h04, 8'h00, 8'hFF);
		analog_absent <= 1'b0;
		repeat (10) @(posedge mclk_i);
		rchk(8'h03, 8'h00, 8'hFF);
		// Flag rise reaches status on the same edge as a clear of that bit
		@(posedge mclk_i);
		analog_absent <= 1'b1;
		@(posedge mclk_i);
		wr(8'h04, 8'h02);
		rchk(8'h04, 8'h12, 8'hFF);
		analog_absent <= 1'b0;
		wr(8'h04, 8'hFF);
		$display("test analogue and interrupt done");

		for (int i = 0; i < 12; i++) begin
			wr(8'h06, f_ctrl[i]);
			ja_fill <= f_fill[i];
			repeat (4) @(posedge mclk_i);
			rchk(8'h03, f_exp[i], 8'hFF);
		end
		ja_fill <= 6'h08;
		$display("test fifo limit done");

		wr(8'h06, 8'h01);
		bits(40);
		rchk(8'h03, 8'h00, 8'h02);
		pattern <= 32'h00000000;
		bits(24);
		rchk(8'h03, 8'h00, 8'h02);
		bits(16);
		rchk(8'h03, 8'h02, 8'h02);
		pattern <= 32'h01010101;
		bits(64);
		rchk(8'h03, 8'h02, 8'h02);
		pattern <= 32'h49249249;
		bits(40);
		rchk(8'h03, 8'h00, 8'h02);
		// E3 ignores the analogue flag; STS-1 ORs it in
		analog_absent <= 1'b1;
		repeat (10) @(posedge mclk_i);
		rchk(8'h03, 8'h10, 8'hFF);
		wr(8'h06, 8'h02);
		rchk(8'h03, 8'h12, 8'hFF);
		analog_absent <= 1'b0;
		pattern <= 32'hFFFFFFFF;
		wr(8'h06, 8'h00);
		bits(40);
		$display("test e3 absence done");

		// Two full windows so a window straddling the change is flushed
		skew <= 1'b1;
		repeat (5000) @(posedge mclk_i);
		rchk(8'h03, 8'h04, 8'hFF);
		wr(8'h06, 8'h04);
		repeat (5000) @(posedge mclk_i);
		rchk(8'h03, 8'h00, 8'hFF);
		skew <= 1'b0;
		repeat (5000) @(posedge mclk_i);
		rchk(8'h03, 8'h04, 8'hFF);
		$display("test clock lock done");
		final_report();
	end
endmodule : rx_channel_alarm_monitor_test
